// ===== program_sequencer.sv
// Program flow sequencer: phases, program counter, vectors, return stack, table reads
//
// Behaviour
// - Four clock phases form one instruction cycle.
// - Next word is fetched while the current one executes.
// - Instructions that change the counter take two cycles via a dummy.
// - Counter is twelve bits wide, 4096 words.
// - Counter increments by one after each fetch.
// - Taken skip discards the fetched word; counter advances by two.
// - Writing the low byte register jumps within the current 256-word page.
// - Reset loads counter with zero.
// - External lines 0 and 1 vector to 004H and 008H.
// - Timer 0 and timer 1 overflows vector to 00CH and 010H.
// - Time base and clock interrupts vector to 014H and 018H.
// - Jump and call load the full target; returns load stack top.
// - Program memory is 4096 by 15, addressed by counter or lookup.
// - Lookup page is counter bits 11-8 or all ones.
// - Lookup low byte to data memory, upper seven bits to high byte.
// - Every lookup instruction takes two cycles.
// - Six-level stack, invisible to software.
// - Call and acknowledge push counter; returns pop it.
// - Reset leaves the stack empty.
// - Full stack records requests but withholds acknowledge until a pop.
// - Call on full stack drops the oldest entry.
// - Acknowledge clears the global enable; flags still record.
// - Only the counter is stacked, never status.
`timescale 1ns/10ps
`default_nettype none
`include "program_sequencer_regs.svh"
module program_sequencer #(
   parameter int STACK_DEPTH = 6,
   parameter int IRQ_COUNT   = 6
) (
   input  wire logic                         core_clk,
   input  wire logic                         rst_n,
   output logic      [11:0]                  prog_addr,
   input  wire logic [14:0]                  prog_data,
   output logic      [14:0]                  instr_word,
   output logic                              instr_valid,
   output logic                              cycle_end,
   input  wire program_sequencer_pkg::seq_op_t dec_op,
   input  wire logic                         dec_skip_met,
   input  wire logic [11:0]                  dec_target,
   input  wire logic [7:0]                   dec_low_byte,
   output logic      [7:0]                   lookup_low,
   output logic                              lookup_low_wr,
   input  wire logic [IRQ_COUNT-1:0]         irq_req,
   output logic                              irq_ack,
   output logic      [IRQ_COUNT-1:0]         irq_ack_sel,
   input  wire logic [7:0]                   paddr,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr
);
   import program_sequencer_pkg::*;

   logic [1:0]           phase;
   logic [11:0]          pc;
   logic [11:0]          next_pc;
   logic [11:0]          lookup_addr;
   logic                 exec_valid;
   logic                 stall;
   logic                 flush;
   logic                 open_slot;
   logic                 stk_push;
   logic                 stk_pop;
   logic                 stk_full;
   logic [11:0]          stk_top;
   logic                 global_irq_enable;
   logic [IRQ_COUNT-1:0] irq_enable;
   logic [IRQ_COUNT-1:0] irq_flag;
   logic [IRQ_COUNT-1:0] irq_live;
   logic [11:0]          irq_vector;
   logic [7:0]           lookup_pointer;
   logic [7:0]           lookup_high_byte;
   logic                 jump_pend;
   logic [7:0]           jump_low;
   logic                 boundary;
   logic                 is_lookup;
   seq_op_t              op;
   logic                 apb_wr;
   logic                 apb_setup;
   logic [5:0]           reg_idx;
   logic                 mapped;

   // ----------------------------------------------------------------
   // Phase generator
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   assign boundary  = (phase == 2'(`PHASES_PER_CYCLE - 1));
   assign cycle_end = boundary;

   // ----------------------------------------------------------------
   // Flow decision at each instruction boundary
   // ----------------------------------------------------------------
   // A dummy or stalled slot decodes as plain sequential flow
   assign op        = (exec_valid && !stall) ? dec_op : op_next;
   assign is_lookup = (op == op_read_lookup_current_page) || (op == op_read_lookup_last_page);
   assign open_slot = boundary && !stall && ((op == op_next) || (op == op_skip && !dec_skip_met));
   assign irq_live  = irq_flag & irq_enable;
   assign irq_ack   = open_slot && !jump_pend && global_irq_enable && !stk_full && (irq_live != '0);

   // Lowest index is the lowest vector
   always_comb begin
      irq_ack_sel = '0;
      for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
         if (irq_live[i]) begin
            irq_ack_sel = '0;
            irq_ack_sel[i] = irq_ack;
         end
      end
   end

   always_comb begin
      irq_vector = `VEC_RTC;
      priority case (1'b1)
         irq_live[0]: irq_vector = `VEC_EXT_IRQ_0;
         irq_live[1]: irq_vector = `VEC_EXT_IRQ_1;
         irq_live[2]: irq_vector = `VEC_TIMER_0;
         irq_live[3]: irq_vector = `VEC_TIMER_1;
         irq_live[4]: irq_vector = `VEC_TIME_BASE;
         default:     irq_vector = `VEC_RTC;
      endcase
   end

   always_comb begin
      next_pc = pc + 12'h001;
      flush   = 1'b0;
      unique case (op)
         op_jump, op_call: begin
            next_pc = dec_target;
            flush   = 1'b1;
         end
         op_return_from_call, op_return_from_service: begin
            next_pc = stk_top;
            flush   = 1'b1;
         end
         op_low_byte_write: begin
            next_pc = {pc[11:8], dec_low_byte};
            flush   = 1'b1;
         end
         op_skip: begin
            flush = dec_skip_met;
         end
         op_next, op_read_lookup_current_page, op_read_lookup_last_page: begin
            flush = 1'b0;
         end
      endcase
      if (open_slot && jump_pend) begin
         next_pc = {pc[11:8], jump_low};
         flush   = 1'b1;
      end else if (irq_ack) begin
         next_pc = irq_vector;
         flush   = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Counter and pipeline registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc          <= `RST_PC;
         instr_word  <= 15'h0000;
         exec_valid  <= 1'b0;
         stall       <= 1'b0;
         lookup_addr <= 12'h000;
      end else if (boundary) begin
         if (stall) begin
            stall      <= 1'b0;
            exec_valid <= 1'b1;
         end else begin
            pc         <= next_pc;
            instr_word <= prog_data;
            exec_valid <= !flush;
            stall      <= is_lookup;
            lookup_addr <= {(op == op_read_lookup_last_page) ? `LAST_PAGE_BITS : pc[11:8],
                            lookup_pointer};
         end
      end
   end

   // Memory serves the lookup while stalled, so the counter stays put
   assign prog_addr   = stall ? lookup_addr : pc;
   assign instr_valid = exec_valid && !stall;

   // ----------------------------------------------------------------
   // Table lookup results
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lookup_low       <= 8'h00;
         lookup_low_wr    <= 1'b0;
         lookup_high_byte <= `RST_LOOKUP_HIGH_BYTE;
      end else begin
         lookup_low_wr <= boundary && stall;
         if (boundary && stall) begin
            lookup_low       <= prog_data[7:0];
            lookup_high_byte <= {1'b0, prog_data[14:8]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Return stack
   // ----------------------------------------------------------------
   // Only the counter goes on the stack; status is left to software
   assign stk_push = boundary && !stall && ((op == op_call) || irq_ack);
   assign stk_pop  = boundary && !stall && ((op == op_return_from_call) || (op == op_return_from_service));

   return_stack #(
      .DEPTH (STACK_DEPTH),
      .WIDTH (12)
   ) return_stack_i (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .push      (stk_push),
      .pop       (stk_pop),
      .push_data (pc),
      .top       (stk_top),
      .full      (stk_full),
      .empty     ()
   );

   // ----------------------------------------------------------------
   // Interrupt flags and enables
   // ----------------------------------------------------------------
   // A request arriving with its acknowledge stays recorded
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_flag <= '0;
      end else begin
         irq_flag <= (irq_flag & ~irq_ack_sel) | irq_req;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         global_irq_enable <= 1'b0;
         irq_enable        <= `RST_IRQ_ENABLES;
      end else begin
         if (irq_ack) begin
            global_irq_enable <= 1'b0;
         end else if (stk_pop && op == op_return_from_service) begin
            global_irq_enable <= 1'b1;
         end else if (apb_wr && reg_idx == `IDX_IRQ_CONTROL) begin
            global_irq_enable <= pwdata[`IRQ_CTRL_GLOBAL_BIT];
         end
         if (apb_wr && reg_idx == `IDX_IRQ_CONTROL) begin
            irq_enable <= pwdata[`IRQ_CTRL_EN_LSB +: IRQ_COUNT];
         end
      end
   end

   // ----------------------------------------------------------------
   // APB register slave
   // ----------------------------------------------------------------
   assign reg_idx   = paddr[7:2];
   assign mapped    = (paddr[1:0] == 2'h0) && (reg_idx >= `IDX_PC_LOW_BYTE) && (reg_idx <= `IDX_IRQ_STATUS);
   assign apb_wr    = psel && penable && pwrite && mapped;
   assign apb_setup = psel && !penable;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !mapped;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lookup_pointer <= `RST_LOOKUP_POINTER;
      end else if (apb_wr && reg_idx == `IDX_LOOKUP_POINTER) begin
         lookup_pointer <= pwdata[7:0];
      end
   end

   // Software jump waits for the next free instruction boundary
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         jump_pend <= 1'b0;
         jump_low  <= 8'h00;
      end else if (apb_wr && reg_idx == `IDX_PC_LOW_BYTE) begin
         jump_pend <= 1'b1;
         jump_low  <= pwdata[7:0];
      end else if (open_slot) begin
         jump_pend <= 1'b0;
      end
   end

   // Read data is latched in the setup phase so the access needs no wait
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup) begin
         prdata <= 32'h0000_0000;
         unique case (mapped ? reg_idx : 6'h00)
            `IDX_PC_LOW_BYTE:      prdata[7:0] <= pc[7:0];
            `IDX_LOOKUP_POINTER:   prdata[7:0] <= lookup_pointer;
            `IDX_LOOKUP_HIGH_BYTE: prdata[7:0] <= lookup_high_byte;
            `IDX_IRQ_CONTROL:      prdata[IRQ_COUNT:0] <= {irq_enable, global_irq_enable};
            `IDX_IRQ_STATUS:       prdata[IRQ_COUNT-1:0] <= irq_flag;
            default:               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_boundary_free;
      boundary && !stall;
   endsequence
   sequence s_dummy_cycle;
      !instr_valid [*4];
   endsequence

   a_phase_wrap:    assert property (boundary |=> phase == 2'h0 ##3 boundary)
      else $error("instruction cycle is not four clocks");
   a_pc_step:       assert property (s_boundary_free ##0 (!flush) |=> pc == $past(pc) + 12'h001)
      else $error("counter did not advance by one");
   a_jump_target:   assert property (s_boundary_free ##0 (op == op_jump) |=> pc == $past(dec_target) ##0 s_dummy_cycle)
      else $error("jump target or dummy cycle wrong");
   a_skip_dummy:    assert property (s_boundary_free ##0 (op == op_skip && dec_skip_met && !irq_ack && !jump_pend)
                                    |=> pc == $past(pc) + 12'h001 ##0 s_dummy_cycle)
      else $error("taken skip did not discard the next word");
   a_return_target: assert property (s_boundary_free ##0 (op == op_return_from_call) |=> pc == $past(stk_top))
      else $error("return did not load the stack top");
   a_full_holds:    assert property (stk_full |-> !irq_ack)
      else $error("interrupt taken on full stack");
   a_ack_vector:    assert property (irq_ack && irq_live[0] |=> pc == `VEC_EXT_IRQ_0 && !global_irq_enable)
      else $error("acknowledge vector or enable wrong");
   a_lookup_two:    assert property (s_boundary_free ##0 is_lookup |=> stall ##4 (lookup_low_wr && !stall))
      else $error("lookup did not complete in two cycles");
   a_high_top_zero: assert property (lookup_high_byte[7] == 1'b0)
      else $error("high byte top bit set");
endmodule
`default_nettype wire

// ===== program_sequencer_regs.svh
// Register indices, field positions, reset values and vectors of the program sequencer
`ifndef PROGRAM_SEQUENCER_REGS_SVH
`define PROGRAM_SEQUENCER_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PC_LOW_BYTE      6'h06
`define IDX_LOOKUP_POINTER   6'h07
`define IDX_LOOKUP_HIGH_BYTE 6'h08
`define IDX_IRQ_CONTROL      6'h09
`define IDX_IRQ_STATUS       6'h0a

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define IRQ_CTRL_GLOBAL_BIT  0
`define IRQ_CTRL_EN_LSB      1
`define RST_LOOKUP_POINTER   8'h00
`define RST_LOOKUP_HIGH_BYTE 8'h00
`define RST_IRQ_ENABLES      6'h00
`define RST_PC               12'h000

// ----------------------------------------------------------------
// Timing and fixed addresses
// ----------------------------------------------------------------
`define PHASES_PER_CYCLE     4
`define LAST_PAGE_BITS       4'hf
`define VEC_EXT_IRQ_0        12'h004
`define VEC_EXT_IRQ_1        12'h008
`define VEC_TIMER_0          12'h00c
`define VEC_TIMER_1          12'h010
`define VEC_TIME_BASE        12'h014
`define VEC_RTC              12'h018

`endif

// ===== program_sequencer_pkg.sv
// Types shared by the program sequencer and its decoder-facing ports
package program_sequencer_pkg;
   typedef enum logic [3:0] {
      op_next, op_skip, op_jump, op_call, op_return_from_call, op_return_from_service,
      op_low_byte_write, op_read_lookup_current_page, op_read_lookup_last_page
   } seq_op_t;
endpackage

// ===== return_stack.sv
// Return address stack with overflow that drops the oldest entry
`timescale 1ns/10ps
`default_nettype none
module return_stack #(
   parameter int DEPTH = 6,
   parameter int WIDTH = 12
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] top,
   output logic                  full,
   output logic                  empty
);
   logic [WIDTH-1:0]         entry [DEPTH];
   logic [$clog2(DEPTH+1)-1:0] return_stack_index;

   // ----------------------------------------------------------------
   // Entries: entry 0 is the most recent address
   // ----------------------------------------------------------------
   // Shifting keeps overflow trivial: the deepest entry falls off the end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            entry[i] <= '0;
         end
      end else if (push) begin
         entry[0] <= push_data;
         for (int i = 1; i < DEPTH; i++) begin
            entry[i] <= entry[i-1];
         end
      end else if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            entry[i] <= entry[i+1];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         return_stack_index <= '0;
      end else if (push && !full) begin
         return_stack_index <= return_stack_index + 1'b1;
      end else if (pop && !empty) begin
         return_stack_index <= return_stack_index - 1'b1;
      end
   end

   assign top   = entry[0];
   assign full  = (return_stack_index == ($clog2(DEPTH+1))'(DEPTH));
   assign empty = (return_stack_index == '0);
endmodule
`default_nettype wire

// ===== program_memory_model.sv
// Program memory model: 4096 words of 15 bits, combinational read
`timescale 1ns/10ps
`default_nettype none
module program_memory_model (
   input  wire logic [11:0] prog_addr,
   output logic      [14:0] prog_data
);
   // Word mixes address bits so a wrong page or offset shows in the data
   assign prog_data = {prog_addr[2:0] ^ 3'h5, prog_addr};
endmodule
`default_nettype wire

// ===== program_sequencer_tb.sv
// Self-checking testbench of the program sequencer
`timescale 1ns/10ps
`default_nettype none
module program_sequencer_tb;
   import program_sequencer_pkg::*;
   typedef struct {seq_op_t op; logic sk; logic [11:0] tgt; logic [7:0] pd;} cmd_t;
   logic        core_clk, rst_n, instr_valid, cycle_end, dec_skip_met, lookup_low_wr, irq_ack;
   logic [11:0] prog_addr, dec_target, ep, la;
   logic [14:0] prog_data, instr_word;
   logic [7:0]  dec_low_byte, lookup_low, paddr, lk_ptr, jump_low;
   logic [5:0]  irq_req, irq_ack_sel;
   logic        psel, penable, pwrite, pready, pslverr, jump_pend, ph_seen;
   logic [31:0] pwdata, prdata, r;
   seq_op_t     dec_op;
   int          miscompares, total_checks, ph, i;
   logic [14:0] exp_q[$], lk_q[$];
   logic [11:0] stk[$];
   int          irq_q[$];
   cmd_t        cmd_q[$];

   program_sequencer program_sequencer_i (.core_clk(core_clk), .rst_n(rst_n), .prog_addr(prog_addr),
      .prog_data(prog_data), .instr_word(instr_word), .instr_valid(instr_valid), .cycle_end(cycle_end),
      .dec_op(dec_op), .dec_skip_met(dec_skip_met), .dec_target(dec_target), .dec_low_byte(dec_low_byte),
      .lookup_low(lookup_low), .lookup_low_wr(lookup_low_wr), .irq_req(irq_req), .irq_ack(irq_ack),
      .irq_ack_sel(irq_ack_sel), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   program_memory_model program_memory_model_i (.prog_addr(prog_addr), .prog_data(prog_data));

   function automatic logic [14:0] rom(input logic [11:0] a);
      return {a[2:0] ^ 3'h5, a};
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic spush(input logic [11:0] a);
      if (stk.size() == 6) stk.delete(0);
      stk.push_back(a);
   endtask
   task automatic take(inout logic [11:0] a);
      int s;
      if (irq_q.size() == 0) begin
         chk(1, 0);
         return;
      end
      s = irq_q.pop_front();
      chk(irq_ack_sel, 6'h01 << s);
      spush(a);
      a = 12'(4 * (s + 1));
   endtask
   task automatic cmd(input seq_op_t op, input logic sk, input logic [11:0] t, input logic [7:0] d);
      cmd_q.push_back('{op, sk, t, d});
   endtask
   task automatic idle(input int k);
      while (cmd_q.size() > 0 || irq_q.size() > k) @(posedge core_clk);
      repeat (16) @(posedge core_clk);
   endtask
   task automatic pulse(input logic [5:0] m);
      @(posedge core_clk) irq_req <= m;
      @(posedge core_clk) irq_req <= '0;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ex,
                      input logic er);
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      if (w && a == 8'h18) begin
         jump_low = wd[7:0];
         jump_pend = 1'b1;
      end
      if (w && a == 8'h1c) lk_ptr = wd[7:0];
      chk(pslverr, er);
      if (!w) chk(prdata, ex);
      psel <= 1'b0; penable <= 1'b0;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      conclude();
   end

   // Instruction stream driver; runs the decoder side one cycle at a time
   initial begin : runner
      cmd_t c;
      logic [11:0] nxt, ep1;
      logic xf;
      @(posedge rst_n);
      forever begin
         c = '{op_next, 1'b0, 12'h000, 8'h00};
         if (cmd_q.size() > 0) c = cmd_q.pop_front();
         dec_op <= c.op; dec_skip_met <= c.sk; dec_target <= c.tgt; dec_low_byte <= c.pd;
         do begin
            @(negedge core_clk);
            if (cycle_end === 1'b1 && instr_valid !== 1'b1 && irq_ack === 1'b1) take(ep);
         end while (!(cycle_end === 1'b1 && instr_valid === 1'b1));
         exp_q.push_back(rom(ep));
         ep1 = ep + 12'h001;
         xf = 1'b1;
         case (c.op)
            op_skip: begin
               nxt = c.sk ? ep + 12'h002 : ep1;
               xf = c.sk;
            end
            op_jump: nxt = c.tgt;
            op_call: begin
               spush(ep1);
               nxt = c.tgt;
            end
            op_return_from_call, op_return_from_service: nxt = stk.pop_back();
            op_low_byte_write: nxt = {ep1[11:8], c.pd};
            op_read_lookup_current_page, op_read_lookup_last_page: begin
               la = {(c.op == op_read_lookup_last_page) ? 4'hf : ep1[11:8], lk_ptr};
               lk_q.push_back(rom(la));
               nxt = ep1;
            end
            default: begin
               nxt = ep1;
               xf = 1'b0;
            end
         endcase
         if (jump_pend && !xf) begin
            nxt = {ep1[11:8], jump_low};
            jump_pend = 1'b0;
            xf = 1'b1;
         end
         if (irq_ack === 1'b1) begin
            take(nxt);
            xf = 1'b1;
         end
         @(posedge core_clk);
         ep = nxt;
         if (xf) begin
            @(negedge core_clk);
            chk(instr_valid, 1'b0);
            @(posedge core_clk);
         end
      end
   end

   // Result watchers take the oldest note whenever a result shows
   always @(posedge core_clk) begin
      if (rst_n === 1'b1 && cycle_end === 1'b1 && instr_valid === 1'b1) begin
         if (exp_q.size() == 0) chk(1, 0);
         else chk(instr_word, exp_q.pop_front());
      end
      if (lookup_low_wr === 1'b1) begin
         if (lk_q.size() == 0) chk(1, 0);
         else chk(lookup_low, lk_q.pop_front() & 15'h00ff);
      end
      if (rst_n === 1'b1) begin
         ph++;
         if (cycle_end === 1'b1) begin
            if (ph_seen) chk(ph, 4);
            ph = 0;
            ph_seen = 1'b1;
         end
      end
   end

   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      dec_op = op_next; dec_skip_met = 1'b0; dec_target = '0; dec_low_byte = '0; irq_req = '0;
      miscompares = 0; total_checks = 0; ep = '0; la = '0; lk_ptr = '0; jump_low = '0; jump_pend = 1'b0;
      ph = 0; ph_seen = 1'b0; r = 32'ha4a2;
      repeat (12) @(posedge core_clk);
      chk(prog_addr, 12'h000);
      rst_n <= 1'b1;
      apb(0, 8'h1c, 0, 0, 0);
      apb(0, 8'h24, 0, 0, 0);
      apb(0, 8'h2c, 0, 0, 1);
      apb(0, 8'h1d, 0, 0, 1);
      r = lfsr(r);
      apb(1, 8'h1c, {24'hffffff, r[7:0]}, 0, 0);
      apb(0, 8'h1c, 0, {24'h0, r[7:0]}, 0);
      for (i = 0; i < 4; i++) begin
         r = lfsr(lfsr(r));
         cmd(op_jump, 0, r[11:0], 0);
         cmd(op_skip, 1, 0, 0);
         cmd(op_skip, 0, 0, 0);
         cmd(op_low_byte_write, 0, 0, r[19:12]);
         cmd(op_call, 0, r[27:16], 0);
         cmd(op_read_lookup_current_page, 0, 0, 0);
         cmd(op_return_from_call, 0, 0, 0);
         cmd(i[0] ? op_read_lookup_last_page : op_read_lookup_current_page, 0, 0, 0);
      end
      idle(0);
      apb(1, 8'h20, 32'h7f, 0, 0);
      apb(0, 8'h20, 0, 32'(rom(la) >> 8), 0);
      r = lfsr(r);
      apb(1, 8'h18, r, 0, 0);
      idle(0);
      for (i = 0; i < 7; i++) begin
         r = lfsr(r);
         cmd(op_call, 0, r[11:0], 0);
      end
      idle(0);
      apb(1, 8'h24, 32'h41, 0, 0);
      pulse(6'h20);
      repeat (24) @(posedge core_clk);
      apb(0, 8'h28, 0, 32'h20, 0);
      irq_q.push_back(5);
      cmd(op_return_from_call, 0, 0, 0);
      idle(0);
      chk(irq_q.size(), 0);
      apb(0, 8'h24, 0, 32'h40, 0);
      cmd(op_return_from_service, 0, 0, 0);
      idle(0);
      repeat (stk.size()) cmd(op_return_from_call, 0, 0, 0);
      idle(0);
      for (i = 0; i < 6; i++) begin
         apb(1, 8'h24, 32'h1 | (32'h2 << i), 0, 0);
         irq_q.push_back(i);
         pulse(6'h01 << i);
         idle(0);
         apb(0, 8'h24, 0, 32'h2 << i, 0);
         cmd(op_return_from_service, 0, 0, 0);
         idle(0);
      end
      apb(1, 8'h24, 32'h7f, 0, 0);
      irq_q.push_back(1);
      irq_q.push_back(3);
      pulse(6'h0a);
      idle(1);
      cmd(op_return_from_service, 0, 0, 0);
      idle(0);
      cmd(op_return_from_service, 0, 0, 0);
      idle(0);
      chk(irq_q.size() + stk.size(), 0);
      conclude();
   end
endmodule
`default_nettype wire
